// ---- multilevel_irq_ctrl_map.vh ----
// constants for the multilevel interrupt controller
// assumes a 16-bit program counter holding word addresses
`ifndef MULTILEVEL_IRQ_CTRL_MAP_VH
`define MULTILEVEL_IRQ_CTRL_MAP_VH

// source count and widths
`define IRQ_N_SRC          16
`define IRQ_IDX_W          4
`define IRQ_LVL_W          2
`define IRQ_VEC_W          16
`define IRQ_N_ACT          4

// per-source level field encoding
`define IRQ_LVL_OFF        2'h0
`define IRQ_LVL_LOW        2'h1
`define IRQ_LVL_MED        2'h2
`define IRQ_LVL_HIGH       2'h3

// bit positions of the active-level vector
`define IRQ_ACT_LOW        2'h0
`define IRQ_ACT_MED        2'h1
`define IRQ_ACT_HIGH       2'h2
`define IRQ_ACT_NMI        2'h3

// vector table layout, word addresses
`define IRQ_APP_BASE       16'h0000
`define IRQ_BOOT_BASE      16'hf000
`define IRQ_NMI_OFF        16'h0002
`define IRQ_PERIPH_BASE0   16'h0004
`define IRQ_PERIPH_STEP    16'h0004
`define IRQ_SRC_PER_PERIPH 1
`define IRQ_SRC_OFF_STEP   16'h0002

// reset values
`define IRQ_RR_LAST_RST    4'hf

`endif

// ---- irq_pick.v ----
// lowest-index picker with optional rotation after the last granted index
// assumes requests come from logic on the same clock; purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "multilevel_irq_ctrl_map.vh"

module irq_pick (
  input  wire [`IRQ_N_SRC-1:0] req_i,
  input  wire                  rot_en_i,
  input  wire [`IRQ_IDX_W-1:0] last_i,
  output reg                   any_o,
  output reg  [`IRQ_IDX_W-1:0] idx_o
);

  reg                  hit_above;
  reg [`IRQ_IDX_W-1:0] idx_above;
  integer              k;

  always @* begin
    any_o     = 1'b0;
    idx_o     = {`IRQ_IDX_W{1'b0}};
    hit_above = 1'b0;
    idx_above = {`IRQ_IDX_W{1'b0}};
    // downward scan leaves the lowest set index, which is the lowest vector
    for (k = `IRQ_N_SRC - 1; k >= 0; k = k - 1) begin
      if (req_i[k]) begin
        any_o = 1'b1;
        idx_o = k[`IRQ_IDX_W-1:0];
        if (k[`IRQ_IDX_W-1:0] > last_i) begin
          hit_above = 1'b1;
          idx_above = k[`IRQ_IDX_W-1:0];
        end
      end
    end
    // rotation: first request after the last grant, else wrap to the lowest
    if (rot_en_i && hit_above) begin
      idx_o = idx_above;
    end
  end

endmodule
`default_nettype wire

// ---- multilevel_irq_ctrl.v ----
// multilevel interrupt controller: three levels plus non-maskable request,
// vector formation and a request/acknowledge handshake towards the core
// assumes sources and core run on core_clk_i; the core pulses ack and return
//
// Function
// - each source has its own enable; enabled source requests while its condition holds
// - each source has its own level setting and its own distinct vector
// - on acknowledge the controller loads the program counter with the granted vector
// - each source is set to off, low, medium or high level
// - a medium request preempts a running low-level handler
// - a high request preempts a running medium or low handler
// - within one level the smallest vector address wins
// - optional round-robin among low-level requests only
// - non-maskable request ignores level enables and global enable
// - vector is peripheral base address plus the source's offset
// - vectors are program word addresses
// - a select places the table in application or boot section
`timescale 1ns/1ps
`default_nettype none
`include "multilevel_irq_ctrl_map.vh"

module multilevel_irq_ctrl (
  input  wire                      core_clk_i,
  input  wire                      resetn_i,
  input  wire [`IRQ_N_SRC-1:0]     src_irq_i,
  input  wire [`IRQ_N_SRC-1:0]     src_en_i,
  input  wire [2*`IRQ_N_SRC-1:0]   src_lvl_i,
  input  wire [2:0]                lvl_en_i,
  input  wire                      gie_i,
  input  wire                      rr_en_i,
  input  wire                      boot_vec_i,
  input  wire                      nmi_i,
  input  wire                      cpu_ack_i,
  input  wire                      cpu_reti_i,
  output wire                      irq_req_o,
  output wire [`IRQ_VEC_W-1:0]     irq_vec_o,
  output wire                      pc_load_o,
  output wire [`IRQ_VEC_W-1:0]     pc_vec_o,
  output wire [`IRQ_N_SRC-1:0]     src_clr_o,
  output wire                      nmi_clr_o,
  output wire [`IRQ_N_ACT-1:0]     active_lvl_o,
  output wire [`IRQ_IDX_W-1:0]     rr_last_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  reg [`IRQ_N_ACT-1:0]   active_q;
  reg [`IRQ_N_ACT-1:0]   active_d;
  reg                    req_q;
  reg                    req_d;
  reg [`IRQ_VEC_W-1:0]   vec_q;
  reg [`IRQ_VEC_W-1:0]   vec_d;
  reg [1:0]              sel_act_q;
  reg [1:0]              sel_act_d;
  reg [`IRQ_IDX_W-1:0]   sel_src_q;
  reg [`IRQ_IDX_W-1:0]   sel_src_d;
  reg                    pc_load_q;
  reg [`IRQ_VEC_W-1:0]   pc_vec_q;
  reg [`IRQ_N_SRC-1:0]   src_clr_q;
  reg [`IRQ_N_SRC-1:0]   src_clr_d;
  reg                    nmi_clr_q;
  reg [`IRQ_IDX_W-1:0]   rr_last_q;
  reg [`IRQ_IDX_W-1:0]   rr_last_d;

  ////////////////////////////////////////////////////////////////////////////
  // per-source qualification and vector table

  wire [`IRQ_N_SRC-1:0]        live_low;
  wire [`IRQ_N_SRC-1:0]        live_med;
  wire [`IRQ_N_SRC-1:0]        live_high;
  wire [`IRQ_N_SRC*16-1:0]     vec_tab;
  wire [`IRQ_VEC_W-1:0]        sect_base;

  assign sect_base = boot_vec_i ? `IRQ_BOOT_BASE : `IRQ_APP_BASE;

  genvar gi;
  generate
    for (gi = 0; gi < `IRQ_N_SRC; gi = gi + 1) begin : g_src
      wire [1:0]             lvl;
      wire                   live;
      wire [`IRQ_VEC_W-1:0]  periph_base;
      wire [`IRQ_VEC_W-1:0]  src_off;
      wire [31:0]            periph_full;
      wire [31:0]            off_full;
      assign lvl  = src_lvl_i[2*gi +: 2];
      assign live = src_irq_i[gi] & src_en_i[gi];
      assign live_low[gi]  = live & (lvl == `IRQ_LVL_LOW);
      assign live_med[gi]  = live & (lvl == `IRQ_LVL_MED);
      assign live_high[gi] = live & (lvl == `IRQ_LVL_HIGH);
      // word addresses, two words per entry
      assign periph_full = `IRQ_PERIPH_BASE0
                         + (gi / (`IRQ_SRC_PER_PERIPH + 1)) * `IRQ_PERIPH_STEP;
      assign off_full    = (gi % (`IRQ_SRC_PER_PERIPH + 1)) * `IRQ_SRC_OFF_STEP;
      assign periph_base = periph_full[`IRQ_VEC_W-1:0];
      assign src_off     = off_full[`IRQ_VEC_W-1:0];
      assign vec_tab[16*gi +: 16] = sect_base + periph_base + src_off;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // arbitration inside each level

  wire                   any_low;
  wire                   any_med;
  wire                   any_high;
  wire [`IRQ_IDX_W-1:0]  idx_low;
  wire [`IRQ_IDX_W-1:0]  idx_med;
  wire [`IRQ_IDX_W-1:0]  idx_high;

  irq_pick u_pick_low (
    .req_i    (live_low),
    .rot_en_i (rr_en_i),
    .last_i   (rr_last_q),
    .any_o    (any_low),
    .idx_o    (idx_low)
  );

  irq_pick u_pick_med (
    .req_i    (live_med),
    .rot_en_i (1'b0),
    .last_i   (rr_last_q),
    .any_o    (any_med),
    .idx_o    (idx_med)
  );

  irq_pick u_pick_high (
    .req_i    (live_high),
    .rot_en_i (1'b0),
    .last_i   (rr_last_q),
    .any_o    (any_high),
    .idx_o    (idx_high)
  );

  ////////////////////////////////////////////////////////////////////////////
  // arbitration between levels

  wire cand_nmi;
  wire cand_high;
  wire cand_med;
  wire cand_low;
  wire ack_take;

  // only a strictly higher level than every active one may enter
  assign cand_nmi  = nmi_i & ~active_q[`IRQ_ACT_NMI];
  assign cand_high = gie_i & lvl_en_i[2] & any_high
                   & ~(|active_q[`IRQ_ACT_NMI:`IRQ_ACT_HIGH]);
  assign cand_med  = gie_i & lvl_en_i[1] & any_med
                   & ~(|active_q[`IRQ_ACT_NMI:`IRQ_ACT_MED]);
  assign cand_low  = gie_i & lvl_en_i[0] & any_low
                   & ~(|active_q);

  assign ack_take = cpu_ack_i & req_q;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always @* begin
    active_d  = active_q;
    req_d     = 1'b0;
    vec_d     = vec_q;
    sel_act_d = sel_act_q;
    sel_src_d = sel_src_q;
    src_clr_d = {`IRQ_N_SRC{1'b0}};
    rr_last_d = rr_last_q;

    // return clears the highest active level first
    if (cpu_reti_i) begin
      if (active_q[`IRQ_ACT_NMI]) begin
        active_d[`IRQ_ACT_NMI] = 1'b0;
      end else if (active_q[`IRQ_ACT_HIGH]) begin
        active_d[`IRQ_ACT_HIGH] = 1'b0;
      end else if (active_q[`IRQ_ACT_MED]) begin
        active_d[`IRQ_ACT_MED] = 1'b0;
      end else begin
        active_d[`IRQ_ACT_LOW] = 1'b0;
      end
    end

    if (ack_take) begin
      // grant: set after clear so a same-cycle entry is not lost
      active_d[sel_act_q] = 1'b1;
      if (sel_act_q != `IRQ_ACT_NMI) begin
        src_clr_d[sel_src_q] = 1'b1;
      end
      if (sel_act_q == `IRQ_ACT_LOW) begin
        rr_last_d = sel_src_q;
      end
    end else if (!cpu_reti_i) begin
      // request held one cycle low after ack or return to let state settle
      if (cand_nmi) begin
        req_d     = 1'b1;
        sel_act_d = `IRQ_ACT_NMI;
        sel_src_d = {`IRQ_IDX_W{1'b0}};
        vec_d     = sect_base + `IRQ_NMI_OFF;
      end else if (cand_high) begin
        req_d     = 1'b1;
        sel_act_d = `IRQ_ACT_HIGH;
        sel_src_d = idx_high;
        vec_d     = vec_tab[16*idx_high +: 16];
      end else if (cand_med) begin
        req_d     = 1'b1;
        sel_act_d = `IRQ_ACT_MED;
        sel_src_d = idx_med;
        vec_d     = vec_tab[16*idx_med +: 16];
      end else if (cand_low) begin
        req_d     = 1'b1;
        sel_act_d = `IRQ_ACT_LOW;
        sel_src_d = idx_low;
        vec_d     = vec_tab[16*idx_low +: 16];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      active_q  <= {`IRQ_N_ACT{1'b0}};
      req_q     <= 1'b0;
      vec_q     <= {`IRQ_VEC_W{1'b0}};
      sel_act_q <= 2'h0;
      sel_src_q <= {`IRQ_IDX_W{1'b0}};
      pc_load_q <= 1'b0;
      pc_vec_q  <= {`IRQ_VEC_W{1'b0}};
      src_clr_q <= {`IRQ_N_SRC{1'b0}};
      nmi_clr_q <= 1'b0;
      rr_last_q <= `IRQ_RR_LAST_RST;
    end else begin
      active_q  <= active_d;
      req_q     <= req_d;
      vec_q     <= vec_d;
      sel_act_q <= sel_act_d;
      sel_src_q <= sel_src_d;
      pc_load_q <= ack_take;
      pc_vec_q  <= ack_take ? vec_q : pc_vec_q;
      src_clr_q <= src_clr_d;
      nmi_clr_q <= ack_take & (sel_act_q == `IRQ_ACT_NMI);
      rr_last_q <= rr_last_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign irq_req_o    = req_q;
  assign irq_vec_o    = vec_q;
  assign pc_load_o    = pc_load_q;
  assign pc_vec_o     = pc_vec_q;
  assign src_clr_o    = src_clr_q;
  assign nmi_clr_o    = nmi_clr_q;
  assign active_lvl_o = active_q;
  assign rr_last_o    = rr_last_q;

endmodule
`default_nettype wire

// ---- irq_ctrl_chk.sv ----
// port assertions for the multilevel interrupt controller
// assumes one clock domain and the map header on the include path
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_chk (
  input wire logic        core_clk_i,
  input wire logic        resetn_i,
  input wire logic        gie_i,
  input wire logic        nmi_i,
  input wire logic        boot_vec_i,
  input wire logic        cpu_ack_i,
  input wire logic        cpu_reti_i,
  input wire logic        irq_req_o,
  input wire logic [15:0] irq_vec_o,
  input wire logic        pc_load_o,
  input wire logic [15:0] pc_vec_o,
  input wire logic [15:0] src_clr_o,
  input wire logic        nmi_clr_o,
  input wire logic [3:0]  active_lvl_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  ////////////////////////////////////////////////////////////
  property p_grant;
    irq_req_o && cpu_ack_i |=> pc_load_o && pc_vec_o == $past(irq_vec_o);
  endproperty
  a_grant: assert property (p_grant) else $error("grant lost");
  property p_no_load;
    !(irq_req_o && cpu_ack_i) |=> !pc_load_o;
  endproperty
  a_no_load: assert property (p_no_load) else $error("load without ack");
  property p_one_src;
    pc_load_o |-> $onehot({src_clr_o, nmi_clr_o}) && !irq_req_o;
  endproperty
  a_one_src: assert property (p_one_src) else $error("clear not one-hot");
  property p_pulse;
    pc_load_o |=> !pc_load_o && src_clr_o == 16'h0000;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse too long");
  property p_nmi;
    nmi_clr_o |-> active_lvl_o[3] && pc_vec_o[11:0] == 12'h002;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi grant wrong");
  property p_word;
    irq_req_o |-> irq_vec_o[0] == 1'b0;
  endproperty
  a_word: assert property (p_word) else $error("odd vector");
  property p_sect;
    irq_req_o && $stable(boot_vec_i) |-> irq_vec_o[15:12] == {4{boot_vec_i}};
  endproperty
  a_sect: assert property (p_sect) else $error("wrong section");
  property p_mask;
    $past(!gie_i && !nmi_i) |-> !irq_req_o;
  endproperty
  a_mask: assert property (p_mask) else $error("masked request");
  property p_ret;
    cpu_reti_i && !cpu_ack_i && active_lvl_o != 4'h0 |=> $onehot($past(active_lvl_o) ^ active_lvl_o)
      && ($past(active_lvl_o) ^ active_lvl_o) > active_lvl_o;
  endproperty
  a_ret: assert property (p_ret) else $error("return cleared wrong level");
  c_nmi: cover property (nmi_clr_o);
  c_nest: cover property (active_lvl_o == 4'h7);
  c_boot: cover property (pc_load_o && boot_vec_i);
endmodule
bind multilevel_irq_ctrl irq_ctrl_chk u_chk (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .gie_i(gie_i),
  .nmi_i(nmi_i), .boot_vec_i(boot_vec_i), .cpu_ack_i(cpu_ack_i), .cpu_reti_i(cpu_reti_i), .irq_req_o(irq_req_o),
  .irq_vec_o(irq_vec_o), .pc_load_o(pc_load_o), .pc_vec_o(pc_vec_o), .src_clr_o(src_clr_o),
  .nmi_clr_o(nmi_clr_o), .active_lvl_o(active_lvl_o));
`default_nettype wire

// ---- irq_core_model.sv ----
// core and source model: latches source events, acks requests
// assumes the controller clock; slow_i delays each ack by three cycles
`timescale 1ns/1ps
`default_nettype none
module irq_core_model (
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        slow_i,
  input  wire logic        irq_req_i,
  input  wire logic [15:0] set_i,
  input  wire logic [15:0] clr_i,
  output logic             ack_o,
  output logic      [15:0] src_o
);
  logic [2:0] wait_q;
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      src_o  <= 16'h0000;
      ack_o  <= 1'b0;
      wait_q <= 3'h0;
    end else begin
      src_o  <= (src_o | set_i) & ~clr_i;
      wait_q <= (irq_req_i && !ack_o) ? wait_q + 3'h1 : 3'h0;
      ack_o  <= irq_req_i && !ack_o && (!slow_i || wait_q == 3'h3);
    end
  end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// testbench for the multilevel interrupt controller
// assumes the core model acks requests and clears sources on grant
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        core_clk_i = 1'b0, resetn_i, gie_i, rr_en_i, boot_vec_i, nmi_i, cpu_reti_i, slow;
  logic [15:0] src_en_i, set;
  logic [31:0] src_lvl_i;
  logic [2:0]  lvl_en_i;
  wire         cpu_ack_i, irq_req_o, pc_load_o, nmi_clr_o;
  wire  [15:0] src_irq_i, irq_vec_o, pc_vec_o, src_clr_o;
  wire  [3:0]  active_lvl_o, rr_last_o;
  int          fail_count = 0, tests_run = 0, cyc = 0;
  always #10 core_clk_i = ~core_clk_i;
  multilevel_irq_ctrl u_dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .src_irq_i(src_irq_i),
    .src_en_i(src_en_i), .src_lvl_i(src_lvl_i), .lvl_en_i(lvl_en_i), .gie_i(gie_i), .rr_en_i(rr_en_i),
    .boot_vec_i(boot_vec_i), .nmi_i(nmi_i), .cpu_ack_i(cpu_ack_i), .cpu_reti_i(cpu_reti_i),
    .irq_req_o(irq_req_o), .irq_vec_o(irq_vec_o), .pc_load_o(pc_load_o), .pc_vec_o(pc_vec_o),
    .src_clr_o(src_clr_o), .nmi_clr_o(nmi_clr_o), .active_lvl_o(active_lvl_o), .rr_last_o(rr_last_o));
  irq_core_model u_core (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .slow_i(slow), .irq_req_i(irq_req_o),
    .set_i(set), .clr_i(src_clr_o), .ack_o(cpu_ack_i), .src_o(src_irq_i));
  ////////////////////////////////////////////////////////////
  task step(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] vec(input int i, input logic b);
    vec = (b ? 16'hf000 : 16'h0000) + 16'h0004 + 16'(2 * i);
  endfunction
  task raise(input logic [15:0] m);
    set = m;
    step(1);
    set = 16'h0000;
  endtask
  task take(input logic [15:0] v, input logic [3:0] a);
    int k;
    k = 0;
    while (pc_load_o !== 1'b1 && k < 40) begin
      step(1);
      k++;
    end
    chk({15'h0000, pc_load_o}, 16'h0001);
    chk(pc_vec_o, v);
    chk((v[11:0] == 12'h002) ? {15'h0000, nmi_clr_o} : src_clr_o,
        (v[11:0] == 12'h002) ? 16'h0001 : 16'h0001 << ((v[11:0] - 12'h004) >> 1));
    chk({12'h000, active_lvl_o}, {12'h000, a});
    step(1);
  endtask
  task ret;
    cpu_reti_i = 1'b1;
    step(1);
    cpu_reti_i = 1'b0;
    step(1);
  endtask
  task quiet;
    repeat (6) begin
      step(1);
      chk({15'h0000, irq_req_o}, 16'h0000);
    end
  endtask
  task results;
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      results;
    end
  end
  initial begin
    resetn_i = 1'b0; gie_i = 1'b1; rr_en_i = 1'b0; boot_vec_i = 1'b0; nmi_i = 1'b0; cpu_reti_i = 1'b0;
    slow = 1'b0; src_en_i = 16'hffff; set = 16'h0000; src_lvl_i = {16{2'h1}}; lvl_en_i = 3'h7;
    step(3);
    chk({12'h000, rr_last_o}, 16'h000f);
    resetn_i = 1'b1;
    for (int l = 1; l < 4; l++) begin
      src_lvl_i = {16{l[1:0]}};
      raise(16'h0024);
      take(vec(2, 0), 4'h1 << (l - 1));
      ret;
      take(vec(5, 0), 4'h1 << (l - 1));
      ret;
    end
    $display("test levels done");
    src_lvl_i = {16{2'h1}};
    src_lvl_i[19:18] = 2'h2;
    src_lvl_i[25:24] = 2'h3;
    raise(16'h0002);
    take(vec(1, 0), 4'h1);
    raise(16'h0200);
    take(vec(9, 0), 4'h3);
    raise(16'h1000);
    take(vec(12, 0), 4'h7);
    raise(16'h0001);
    quiet;
    ret;
    chk({12'h000, active_lvl_o}, 16'h0003);
    ret;
    chk({12'h000, active_lvl_o}, 16'h0001);
    ret;
    take(vec(0, 0), 4'h1);
    ret;
    $display("test preempt done");
    src_en_i = 16'hfff7;
    raise(16'h0008);
    quiet;
    src_en_i = 16'hffff;
    take(vec(3, 0), 4'h1);
    ret;
    gie_i = 1'b0;
    raise(16'h0010);
    quiet;
    nmi_i = 1'b1;
    take(16'h0002, 4'h8);
    nmi_i = 1'b0;
    ret;
    lvl_en_i = 3'h6;
    gie_i = 1'b1;
    quiet;
    lvl_en_i = 3'h7;
    take(vec(4, 0), 4'h1);
    ret;
    $display("test masks done");
    rr_en_i = 1'b1;
    slow = 1'b1;
    raise(16'h0014);
    take(vec(2, 0), 4'h1);
    chk({12'h000, rr_last_o}, 16'h0002);
    raise(16'h0002);
    ret;
    take(vec(4, 0), 4'h1);
    ret;
    take(vec(1, 0), 4'h1);
    ret;
    $display("test rotation done");
    boot_vec_i = 1'b1;
    raise(16'h0080);
    take(16'hf012, 4'h1);
    ret;
    $display("test boot done");
    results;
  end
endmodule
`default_nettype wire
